// >>> charge_timer_pkg.sv
// Constants for the charge timer stage-bypass block.
// =====================================================================
package charge_timer_pkg;

    // =================================================================
    // Divider geometry.
    localparam int TIMER_STAGES    = 34;
    localparam int SW1_SKIP        = 19;
    localparam int SW2_SKIP        = 11;
    localparam int GATE_SKIP       = 5;
    localparam int HOLDOFF_SKIP    = 11;
    localparam int GATE_STAGES     = 20;
    localparam int HOLDOFF_STAGES  = 24;
    localparam int LIMIT_BITS      = 3;

    // =================================================================
    // Register map, byte addresses.
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] TIMER_ADDR  = 8'h08;

    // =================================================================
    // Control fields.
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_LIMIT_LSB = 4;
    localparam int LIMIT_W        = 4;
    localparam logic [3:0] LIMIT_MIN   = 4'h2;
    localparam logic [3:0] LIMIT_MAX   = 4'h8;
    localparam logic [3:0] LIMIT_RESET = 4'h8;

    // =================================================================
    // Status fields.
    localparam int ST_FAST_BIT    = 0;
    localparam int ST_SW1_BIT     = 1;
    localparam int ST_SW2_BIT     = 2;
    localparam int ST_SW3_BIT     = 3;
    localparam int ST_EXPIRED_BIT = 4;
    localparam int ST_HOLDOFF_BIT = 5;
    localparam int ST_GATE_BIT    = 6;

endpackage : charge_timer_pkg

// >>> stage_bypass_counter.sv
// Ripple-style divider chain whose low stages can be skipped.
`timescale 1ns/10ps
`default_nettype none
module stage_bypass_counter #(
    parameter int STAGES = 34,
    parameter int SKIP_A = 19,
    parameter int SKIP_B = 11
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              clear,
    input  wire logic              bypass_a,
    input  wire logic              bypass_b,
    output logic [STAGES-1:0]      count_q,
    output logic                   overflow_q
);

    // =================================================================
    // Parameter check.
    if (SKIP_A >= STAGES || SKIP_B >= STAGES || STAGES < 2) begin : g_bad
        $error("stage_bypass_counter: skip count must be below stage count.");
    end

    localparam logic [STAGES:0] ONE    = {{STAGES{1'b0}}, 1'b1};
    localparam logic [STAGES:0] STEP_A = ONE << SKIP_A;
    localparam logic [STAGES:0] STEP_B = ONE << SKIP_B;

    logic [STAGES:0] step;
    logic [STAGES:0] sum;

    // =================================================================
    // Step selection: a bypass feeds the clock straight into a later stage.
    always_comb begin
        if (bypass_a) begin
            step = STEP_A;
        end else if (bypass_b) begin
            step = STEP_B;
        end else begin
            step = ONE;
        end
        sum = {1'b0, count_q} + step;
    end

    // =================================================================
    // Counter stages.
    always_ff @(posedge clk) begin
        if (!rstn || clear) begin
            count_q <= '0;
        end else begin
            count_q <= sum[STAGES-1:0];
        end
    end

    // =================================================================
    // Sticky overflow of the last stage.
    always_ff @(posedge clk) begin
        if (!rstn || clear) begin
            overflow_q <= 1'b0;
        end else if (sum[STAGES]) begin
            overflow_q <= 1'b1;
        end
    end

endmodule // stage_bypass_counter
`default_nettype wire

// >>> charge_timer_test_bypass.sv
// Charge timer with test-mode stage bypass and APB register access.
`timescale 1ns/10ps
`default_nettype none
module charge_timer_test_bypass #(
    parameter int TIMER_STAGES   = charge_timer_pkg::TIMER_STAGES,
    parameter int GATE_STAGES    = charge_timer_pkg::GATE_STAGES,
    parameter int HOLDOFF_STAGES = charge_timer_pkg::HOLDOFF_STAGES
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        battery_sense_input_below,
    input  wire logic        upper_limit_select_input_neg,
    input  wire logic        uvlo_active,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fast_trickle_output,
    output logic             sampling_gate_output,
    output logic             holdoff_done
);

    // =================================================================
    // Parameter check.
    if (TIMER_STAGES < charge_timer_pkg::SW1_SKIP + charge_timer_pkg::LIMIT_BITS ||
        TIMER_STAGES - 2 > 32 ||
        GATE_STAGES <= charge_timer_pkg::GATE_SKIP ||
        HOLDOFF_STAGES <= charge_timer_pkg::HOLDOFF_SKIP) begin : g_bad
        $error("charge_timer_test_bypass: stage counts cannot serve the bypass taps.");
    end

    localparam int TOP_LSB = TIMER_STAGES - charge_timer_pkg::LIMIT_BITS;
    localparam int LIMIT_W = charge_timer_pkg::LIMIT_W;

    // =================================================================
    // Declarations.
    logic                      run_q;
    logic [3:0]                limit_q;
    logic                      sw1_q;
    logic                      sw2_q;
    logic                      sw3_q;
    logic                      below_q;
    logic                      expired_q;
    logic                      timer_clear;
    logic [TIMER_STAGES-1:0]   timer_count;
    logic                      timer_ovf;
    logic [GATE_STAGES-1:0]    gate_count;
    logic [HOLDOFF_STAGES-1:0] holdoff_count;
    logic                      holdoff_ovf;
    logic [3:0]                timer_top;
    logic                      apb_access;
    logic                      apb_commit;
    logic [31:0]               status_word;
    logic [31:0]               ctrl_word;
    logic [31:0]               timer_word;
    logic [31:0]               prdata_q;
    logic                      pready_q;
    logic                      pslverr_q;
    logic                      fast_q;
    logic                      gate_q;
    logic                      holdoff_q;

    // =================================================================
    // Address decode shared by read and write.
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == charge_timer_pkg::CTRL_ADDR) ||
                     (a == charge_timer_pkg::STATUS_ADDR) ||
                     (a == charge_timer_pkg::TIMER_ADDR);
    endfunction

    // =================================================================
    // Test switch detection from the comparator levels.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sw1_q <= 1'b0;
            sw2_q <= 1'b0;
            sw3_q <= 1'b0;
        end else begin
            sw1_q <= battery_sense_input_below & ~upper_limit_select_input_neg;
            sw2_q <= battery_sense_input_below & upper_limit_select_input_neg;
            sw3_q <= upper_limit_select_input_neg;
        end
    end

    // =================================================================
    // Battery sense edge tracking; each window crossing restarts the timer.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            below_q <= 1'b0;
        end else begin
            below_q <= battery_sense_input_below;
        end
    end

    assign timer_clear = (below_q != battery_sense_input_below) | uvlo_active | ~run_q;

    // =================================================================
    // Fast-charge backup timer, 34 stages with two bypass taps.
    stage_bypass_counter #(
        .STAGES (TIMER_STAGES),
        .SKIP_A (charge_timer_pkg::SW1_SKIP),
        .SKIP_B (charge_timer_pkg::SW2_SKIP)
    ) u_timer (
        .clk        (ref_clk),
        .rstn       (rstn),
        .clear      (timer_clear),
        .bypass_a   (sw1_q),
        .bypass_b   (sw2_q),
        .count_q    (timer_count),
        .overflow_q (timer_ovf)
    );

    // =================================================================
    // Sampling gate divider, section A bypass.
    stage_bypass_counter #(
        .STAGES (GATE_STAGES),
        .SKIP_A (charge_timer_pkg::GATE_SKIP),
        .SKIP_B (charge_timer_pkg::GATE_SKIP)
    ) u_gate (
        .clk        (ref_clk),
        .rstn       (rstn),
        .clear      (uvlo_active),
        .bypass_a   (sw3_q),
        .bypass_b   (1'b0),
        .count_q    (gate_count),
        .overflow_q ()
    );

    // =================================================================
    // Trickle holdoff timer, section B bypass.
    stage_bypass_counter #(
        .STAGES (HOLDOFF_STAGES),
        .SKIP_A (charge_timer_pkg::HOLDOFF_SKIP),
        .SKIP_B (charge_timer_pkg::HOLDOFF_SKIP)
    ) u_holdoff (
        .clk        (ref_clk),
        .rstn       (rstn),
        .clear      (timer_clear),
        .bypass_a   (sw3_q),
        .bypass_b   (1'b0),
        .count_q    (holdoff_count),
        .overflow_q (holdoff_ovf)
    );

    // =================================================================
    // Limit compare on the top stages; the overflow counts as eighth eighth.
    assign timer_top = {timer_ovf, timer_count[TIMER_STAGES-1 -: charge_timer_pkg::LIMIT_BITS]};

    always_ff @(posedge ref_clk) begin
        if (!rstn || timer_clear) begin
            expired_q <= 1'b0;
        end else if (timer_top >= limit_q) begin
            expired_q <= 1'b1;
        end
    end

    // =================================================================
    // Pin outputs.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fast_q    <= 1'b0;
            gate_q    <= 1'b0;
            holdoff_q <= 1'b0;
        end else begin
            fast_q    <= run_q & ~uvlo_active & ~expired_q & ~(timer_top >= limit_q);
            gate_q    <= gate_count[GATE_STAGES-1];
            holdoff_q <= holdoff_ovf;
        end
    end

    assign fast_trickle_output  = fast_q;
    assign sampling_gate_output = gate_q;
    assign holdoff_done         = holdoff_q;

    // =================================================================
    // APB slave: one wait state, write commits at the pready edge.
    assign apb_access = psel & penable & ~pready_q;
    assign apb_commit = psel & penable & pready_q;

    assign ctrl_word = {{(32 - charge_timer_pkg::CTRL_LIMIT_LSB - LIMIT_W){1'b0}}, limit_q,
                        {(charge_timer_pkg::CTRL_LIMIT_LSB - 1){1'b0}}, run_q};

    always_comb begin
        status_word = '0;
        status_word[charge_timer_pkg::ST_FAST_BIT]    = fast_q;
        status_word[charge_timer_pkg::ST_SW1_BIT]     = sw1_q;
        status_word[charge_timer_pkg::ST_SW2_BIT]     = sw2_q;
        status_word[charge_timer_pkg::ST_SW3_BIT]     = sw3_q;
        status_word[charge_timer_pkg::ST_EXPIRED_BIT] = expired_q;
        status_word[charge_timer_pkg::ST_HOLDOFF_BIT] = holdoff_q;
        status_word[charge_timer_pkg::ST_GATE_BIT]    = gate_q;
        timer_word = '0;
        timer_word[TIMER_STAGES-TOP_LSB+TOP_LSB-3 -: (TIMER_STAGES-2)] = timer_count[TIMER_STAGES-1:2];
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= apb_access;
            pslverr_q <= apb_access & ~addr_known(paddr);
            if (apb_access && !pwrite) begin
                unique case (paddr)
                    charge_timer_pkg::CTRL_ADDR:   prdata_q <= ctrl_word;
                    charge_timer_pkg::STATUS_ADDR: prdata_q <= status_word;
                    charge_timer_pkg::TIMER_ADDR:  prdata_q <= timer_word;
                    default:                       prdata_q <= '0;
                endcase
            end else if (!apb_access) begin
                prdata_q <= '0;
            end
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    // =================================================================
    // Control register.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            run_q   <= 1'b0;
            limit_q <= charge_timer_pkg::LIMIT_RESET;
        end else if (apb_commit && pwrite && paddr == charge_timer_pkg::CTRL_ADDR) begin
            run_q <= pwdata[charge_timer_pkg::CTRL_RUN_BIT];
            if (pwdata[charge_timer_pkg::CTRL_LIMIT_LSB +: LIMIT_W] >= charge_timer_pkg::LIMIT_MIN &&
                pwdata[charge_timer_pkg::CTRL_LIMIT_LSB +: LIMIT_W] <= charge_timer_pkg::LIMIT_MAX) begin
                limit_q <= pwdata[charge_timer_pkg::CTRL_LIMIT_LSB +: LIMIT_W];
            end
        end
    end

endmodule // charge_timer_test_bypass
`default_nettype wire

// >>> charge_timer_asserts.sv
// Port checker for the charge timer stage-bypass block.
`timescale 1ns/10ps
`default_nettype none
module charge_timer_asserts #(
    parameter int TIMER_STAGES   = 34,
    parameter int GATE_STAGES    = 20,
    parameter int HOLDOFF_STAGES = 24
) (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        battery_sense_input_below,
    input wire logic        upper_limit_select_input_neg,
    input wire logic        uvlo_active,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fast_trickle_output,
    input wire logic        sampling_gate_output,
    input wire logic        holdoff_done
);
    // =================================================================
    // Counters of settled spans in each test condition.
    logic neg_q, gate_q, below_q, chg;
    int   same_q, gap_q, busy_q, hold_q, half, span;
    assign chg  = sampling_gate_output != gate_q;
    assign half = upper_limit_select_input_neg ? 2 ** (GATE_STAGES - 6) : 2 ** (GATE_STAGES - 1);
    assign span = upper_limit_select_input_neg ? 2 ** (TIMER_STAGES - 11) : 2 ** (TIMER_STAGES - 19);
    always_ff @(posedge ref_clk) begin
        neg_q <= upper_limit_select_input_neg;
        gate_q <= sampling_gate_output;
        below_q <= battery_sense_input_below;
        gap_q <= chg ? 1 : gap_q + 1;
        if (!rstn || uvlo_active) begin
            same_q <= 0;
            busy_q <= 0;
            hold_q <= 0;
        end else begin
            same_q <= (upper_limit_select_input_neg == neg_q) ? same_q + 1 : 0;
            busy_q <= (battery_sense_input_below && below_q && upper_limit_select_input_neg == neg_q) ? busy_q + 1 : 0;
            hold_q <= (upper_limit_select_input_neg && neg_q && fast_trickle_output
                       && battery_sense_input_below == below_q) ? hold_q + 1 : 0;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
        else $error("ready without an access");
    a_idle_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside an answer");
    a_uvlo_trickle: assert property (uvlo_active |=> !fast_trickle_output)
        else $error("fast charge during lockout");
    a_gate_rate: assert property (chg && same_q > 2 * half |-> gap_q == half)
        else $error("sampling gate half period wrong");
    a_timer_expiry: assert property (busy_q > span + 8 |-> !fast_trickle_output)
        else $error("timer did not expire in test mode");
    a_holdoff_fast: assert property (hold_q > 2 ** (HOLDOFF_STAGES - 11) + 8 |-> holdoff_done)
        else $error("holdoff not sped up");
endmodule // charge_timer_asserts
bind charge_timer_test_bypass charge_timer_asserts #(.TIMER_STAGES(TIMER_STAGES), .GATE_STAGES(GATE_STAGES),
    .HOLDOFF_STAGES(HOLDOFF_STAGES)) u_chk (.ref_clk, .rstn, .battery_sense_input_below,
    .upper_limit_select_input_neg, .uvlo_active, .psel, .penable, .prdata, .pready, .pslverr,
    .fast_trickle_output, .sampling_gate_output, .holdoff_done);
`default_nettype wire

// >>> charge_timer_test_bypass_tb.sv
// Self-checking testbench for the charge timer stage-bypass block.
`timescale 1ns/10ps
`default_nettype none
module charge_timer_test_bypass_tb;
    // =================================================================
    // Shortened dividers keep the run brief.
    localparam int TS = 24;
    localparam int GS = 12;
    localparam int HS = 15;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        below = 1'b0;
    logic        neg = 1'b0;
    logic        uvlo_active = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, fast, gate, hdone, err;
    int          fail_count = 0;
    int          n_tests = 0;
    int          n, n1, n2, n_base;
    logic [4:0]  rows [4] = '{5'h00, 5'h0C, 5'h11, 5'h1E};
    always #50 ref_clk = ~ref_clk;
    charge_timer_test_bypass #(.TIMER_STAGES(TS), .GATE_STAGES(GS), .HOLDOFF_STAGES(HS)) uut (
        .ref_clk, .rstn, .battery_sense_input_below(below), .upper_limit_select_input_neg(neg), .uvlo_active,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fast_trickle_output(fast),
        .sampling_gate_output(gate), .holdoff_done(hdone));
    task automatic close_out;
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int slack = 0);
        n_tests++;
        if ($isunknown(got) || (slack == 0 ? got !== exp : (got < exp || got > exp + slack))) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? fast : (s == 1 ? gate : hdone);
    endfunction
    task automatic wait_for(input int s, input logic v, output int cnt);
        cnt = 0;
        while (sig(s) !== v && cnt < 40000) begin
            @(posedge ref_clk);
            cnt++;
        end
        if (cnt >= 40000) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (k >= 16) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic expiry(input logic nv, input logic [3:0] lim, output int cnt);
        below <= 1'b0;
        neg <= nv;
        apb(1'b1, 8'h00, {24'h0, lim, 4'h1});
        repeat (3) @(posedge ref_clk);
        chk(fast, 1'b1);
        below <= 1'b1;
        wait_for(0, 1'b0, cnt);
        repeat (16) @(posedge ref_clk);
    endtask
    task automatic gate_half(output int cnt);
        repeat (2) wait_for(1, ~gate, cnt);
        wait_for(1, ~gate, cnt);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({pready, pslverr, fast, gate, hdone}, 0);
        apb(1'b0, 8'h00, 0);
        chk(rd, 32'h80);
        for (int i = 0; i < 4; i++) begin
            below <= rows[i][4];
            neg <= rows[i][3];
            repeat (3) @(posedge ref_clk);
            apb(1'b0, 8'h04, 0);
            chk(rd[3:1], rows[i][2:0]);
        end
        apb(1'b0, 8'h0C, 0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h00, 32'h21);
        apb(1'b1, 8'h00, 32'h91);
        apb(1'b0, 8'h00, 0);
        chk(rd, 32'h21);
        for (int k = 2; k <= 8; k++) begin
            expiry(1'b0, k[3:0], n);
            if (k == 2) n_base = n;
            chk(n, 4 * k, 8);
            chk(n - n_base, 4 * (k - 2));
        end
        apb(1'b0, 8'h04, 0);
        chk({rd[5:4], rd[0]}, 3'b010);
        expiry(1'b1, 4'h8, n);
        chk(n, 8192, 8);
        gate_half(n);
        chk(n, 2 ** (GS - 6));
        neg <= 1'b0;
        gate_half(n);
        chk(n, 2 ** (GS - 1));
        below <= 1'b0;
        wait_for(2, 1'b0, n1);
        wait_for(2, 1'b1, n2);
        chk(n1 + n2, 2 ** HS, 8);
        neg <= 1'b1;
        below <= 1'b1;
        wait_for(2, 1'b0, n1);
        wait_for(2, 1'b1, n2);
        chk(n1 + n2, 2 ** (HS - 11), 8);
        apb(1'b0, 8'h08, 0);
        chk(rd, (n1 + n2 - 2) * 512, 2048);
        uvlo_active <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({fast, gate}, 0);
        uvlo_active <= 1'b0;
        close_out();
    end
endmodule // charge_timer_test_bypass_tb
`default_nettype wire
